// ### dv/triggered_sample_fifo_control_tb.sv
// Purpose: Self-checking bench for the triggered sample buffer control
// Assumes: A small DEPTH keeps fill and overwrite cases short
// Notes: Each word repeats one byte so order shows at a glance
`timescale 1ns/1ps
`include "tsf_map.svh"
module triggered_sample_fifo_control_tb;
	import tsf_pkg::*;
	localparam int DEPTH = 4;
	typedef struct packed {
		logic [2:0] mode;
		logic [3:0] n;
		logic [3:0] lvl;
		logic flag;
	} tsf_row_t;
	logic clk;
	logic rst_n;
	tsf_mode_t mode;
	logic stop_thr;
	logic [8:0] thr;
	logic [4:0] route;
	logic [4:0] evt;
	logic smp_valid;
	logic [55:0] smp_word;
	logic rd_req, rd_restart, rd_ready, rd_valid, rd_ack;
	logic [7:0] rd_byte;
	logic full;
	logic [7:0] lvl_lo;
	logic [1:0] lvl_hi;
	logic trig;
	logic [55:0] w;
	logic ok;
	int err_total;
	int checked;
	tsf_row_t rows [9] = '{'{3'h0, 4'h3, 4'h0, 1'b0}, '{3'h1, 4'h3, 4'h3, 1'b1},
		'{3'h2, 4'h3, 4'h0, 1'b0}, '{3'h3, 4'h3, 4'h3, 1'b1}, '{3'h4, 4'h3, 4'h0, 1'b0},
		'{3'h5, 4'h3, 4'h0, 1'b0}, '{3'h6, 4'h6, 4'h4, 1'b1}, '{3'h7, 4'h3, 4'h0, 1'b0},
		'{3'h1, 4'h6, 4'h4, 1'b1}};

	tsf_ctrl #(.DEPTH(DEPTH)) i_tsf_ctrl (.i_ref_clk(clk), .i_reset_n(rst_n),
		.i_buffer_ctrl_d_mode(mode), .i_stop_at_threshold(stop_thr), .i_threshold_level(thr),
		.i_route_single_tap_l2(route[0]), .i_route_double_tap_l2(route[1]),
		.i_route_freefall_l2(route[2]), .i_route_wakeup_l2(route[3]),
		.i_route_orient_l2(route[4]), .i_evt_single_tap(evt[0]), .i_evt_double_tap(evt[1]),
		.i_evt_freefall(evt[2]), .i_evt_wakeup(evt[3]), .i_evt_orient(evt[4]),
		.i_smp_valid(smp_valid), .i_smp_word(smp_word), .i_rd_req(rd_req),
		.i_rd_restart(rd_restart), .o_rd_ready(rd_ready), .o_rd_byte(rd_byte),
		.o_rd_valid(rd_valid), .i_rd_ack(rd_ack), .o_buffer_full_flag(full),
		.o_buffer_stat_a_level(lvl_lo), .o_buffer_stat_b_level_hi(lvl_hi),
		.o_trig_latched(trig));

	tsf_host_model i_tsf_host_model (.i_ref_clk(clk), .i_rd_ready(rd_ready),
		.i_rd_byte(rd_byte), .i_rd_valid(rd_valid), .o_rd_req(rd_req),
		.o_rd_restart(rd_restart), .o_rd_ack(rd_ack));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [55:0] seen, input logic [55:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic push(input int n, input logic [7:0] v);
		for (int i = 0; i < n; i++) begin
			smp_word = {7{v + 8'(i)}};
			smp_valid = 1'b1;
			step(1);
		end
		smp_valid = 1'b0;
		step(3);
	endtask
	task automatic set_mode(input tsf_mode_t m);
		mode = 3'h0;
		step(2);
		mode = m;
		step(1);
	endtask
	task automatic fire(input int e);
		evt[e] = 1'b1;
		step(2);
		evt[e] = 1'b0;
		step(2);
	endtask
	task automatic stat(input int n, input logic f);
		check({46'h0, lvl_hi, lvl_lo}, 56'(n));
		check({55'h0, full}, {55'h0, f});
	endtask
	task automatic rdw(input logic first, input logic [7:0] v);
		i_tsf_host_model.read_word(first, w, ok);
		check({55'h0, ok}, 56'h1);
		check(w, {7{v}});
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		#1000000;
		err_total++;
		close_out();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		mode = 3'h0;
		stop_thr = 1'b0;
		thr = 9'h000;
		route = 5'h00;
		evt = 5'h00;
		smp_valid = 1'b0;
		smp_word = '0;
		err_total = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		#1;
		rst_n = 1'b1;
		step(1);
		check({52'h0, rd_ready, rd_valid, trig, full}, 56'h8);
		foreach (rows[i]) begin
			set_mode(rows[i].mode);
			push(int'(rows[i].n), 8'h01);
			stat(int'(rows[i].lvl), rows[i].flag);
		end
		set_mode(3'h1);
		push(6, 8'h10);
		for (int k = 0; k < 4; k++) begin
			rdw(k == 0, 8'h10 + 8'(k));
		end
		push(2, 8'h18);
		stat(0, 1'b0);
		rdw(1'b1, 8'h00);
		set_mode(3'h6);
		push(6, 8'h20);
		i_tsf_host_model.lag = 3;
		rdw(1'b1, 8'h22);
		i_tsf_host_model.lag = 0;
		step(3);
		stat(3, 1'b1);
		route = 5'h01;
		set_mode(3'h3);
		push(6, 8'h30);
		fire(0);
		check({55'h0, trig}, 56'h1);
		push(2, 8'h40);
		stat(4, 1'b1);
		rdw(1'b1, 8'h32);
		set_mode(3'h3);
		push(1, 8'h50);
		fire(0);
		push(5, 8'h51);
		stat(4, 1'b1);
		rdw(1'b1, 8'h50);
		rdw(1'b0, 8'h51);
		for (int e = 0; e < 5; e++) begin
			route = 5'h00;
			set_mode(3'h4);
			fire(e);
			push(1, 8'h60);
			check({55'h0, trig}, 56'h0);
			stat(0, 1'b0);
			route = 5'h01 << e;
			fire(e);
			check({55'h0, trig}, 56'h1);
			push(2, 8'h61);
			stat(2, 1'b0);
		end
		route = 5'h01;
		set_mode(3'h7);
		push(2, 8'h70);
		stat(0, 1'b0);
		fire(0);
		push(5, 8'h71);
		stat(4, 1'b1);
		rdw(1'b1, 8'h71);
		push(1, 8'h7f);
		stat(3, 1'b1);
		mode = 3'h0;
		step(3);
		check({55'h0, trig}, 56'h0);
		stat(0, 1'b0);
		thr = 9'h002;
		stop_thr = 1'b1;
		set_mode(3'h1);
		push(1, 8'h80);
		stat(1, 1'b1);
		push(3, 8'h81);
		stat(2, 1'b1);
		stop_thr = 1'b0;
		set_mode(3'h1);
		push(2, 8'h90);
		rst_n = 1'b0;
		step(2);
		stat(0, 1'b0);
		rst_n = 1'b1;
		step(2);
		close_out();
	end
endmodule

// ### dv/tsf_host_model.sv
// Purpose: Host side reader that pulls tagged words byte by byte
// Assumes: The design answers one cycle after it accepts a byte request
// Notes: lag holds the acknowledge back to model a slow host
`timescale 1ns/1ps
module tsf_host_model (
	input wire logic i_ref_clk,
	input wire logic i_rd_ready,
	input wire logic [7:0] i_rd_byte,
	input wire logic i_rd_valid,
	output logic o_rd_req,
	output logic o_rd_restart,
	output logic o_rd_ack
);
	int unsigned lag;

	initial begin
		o_rd_req = 1'b0;
		o_rd_restart = 1'b0;
		o_rd_ack = 1'b0;
		lag = 0;
	end

	// ----------------------------------------------------------------
	// Word read, tag byte first, restart only on the first word
	// ----------------------------------------------------------------
	task automatic read_word(input logic first, output logic [55:0] w, output logic ok);
		int n;
		ok = 1'b1;
		w = '0;
		for (int k = 0; k < 7; k++) begin
			o_rd_req = 1'b1;
			o_rd_restart = first && (k == 0);
			n = 0;
			// Ready and byte are looked at between edges, where they stand settled
			while (!i_rd_ready && n < 40) begin
				@(posedge i_ref_clk);
				#1;
				n++;
			end
			ok &= i_rd_ready;
			@(posedge i_ref_clk);
			#1;
			o_rd_req = 1'b0;
			o_rd_restart = 1'b0;
			repeat (lag) @(posedge i_ref_clk);
			if (lag != 0) #1;
			o_rd_ack = 1'b1;
			ok &= i_rd_valid;
			w[8*k +: 8] = i_rd_byte;
			@(posedge i_ref_clk);
			#1;
			o_rd_ack = 1'b0;
		end
	endtask
endmodule

// ### hw/tsf_ctrl.sv
// Purpose: Mode control, storage and byte readout of a sample buffer
// Assumes: All inputs synchronous to i_ref_clk; 20 MHz clock
// Notes: Word byte 0 is the tag, bytes 1..6 are output data
//
// Functional notes
// RULE_01 - Continuous-then-stop code rings until trigger, then stops when full.
// RULE_02 - Host sets trigger, then batching, then writes the continuous-then-stop code.
// RULE_03 - Trigger is a routed tap, double tap, free-fall, wake-up or orientation event.
// RULE_04 - Only the first rising edge of line 2 changes behaviour.
// RULE_05 - Triggered behaviour holds until the bypass code is written.
// RULE_06 - Full flag rises when the next write fills or overruns the buffer.
// RULE_07 - With stop-at-threshold set, capacity is the threshold level.
// RULE_08 - With stop-at-threshold, flag rises when next write reaches the threshold.
// RULE_09 - Full at trigger: storing stops at the first later sample.
// RULE_10 - Not full at trigger: storing goes on until full, then stops.
// RULE_11 - Idle-then-continuous code stays empty until trigger, then rings.
// RULE_12 - Host sets trigger, batching, then writes the idle-then-continuous code.
// RULE_13 - Idle-then-stop code stays empty until trigger, then fills and stops.
// RULE_14 - After trigger in idle-then-stop, flag rises near full, then storing halts.
// RULE_15 - Host sets trigger, batching, then writes the idle-then-stop code.
// RULE_16 - Reads present the oldest word, then advance and free a slot.
// RULE_17 - Each output read loads the serial output buffer.
// RULE_18 - Stored word count is a 10-bit level split over two status fields.
// RULE_19 - Host reads the level, then that many tagged words.
// RULE_20 - Host avoids reading while the level is zero.
// RULE_21 - Host reads whole seven-byte words starting at the tag.
// RULE_22 - Byte address wraps from the last data byte back to the tag.
// RULE_23 - Bypass code clears the buffer and keeps it empty.
// RULE_24 - Stop-when-full code halts storing when full, content held.
// RULE_25 - Ring code overwrites the oldest word when full.
// RULE_26 - Undescribed mode codes behave as bypass.
`timescale 1ns/1ps
`include "tsf_map.svh"
module tsf_ctrl #(
	parameter int DEPTH = `TSF_DEPTH_DEF
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire tsf_pkg::tsf_mode_t i_buffer_ctrl_d_mode,
	input wire logic i_stop_at_threshold,
	input wire logic [`TSF_THR_W-1:0] i_threshold_level,
	input wire logic i_route_single_tap_l2,
	input wire logic i_route_double_tap_l2,
	input wire logic i_route_freefall_l2,
	input wire logic i_route_wakeup_l2,
	input wire logic i_route_orient_l2,
	input wire logic i_evt_single_tap,
	input wire logic i_evt_double_tap,
	input wire logic i_evt_freefall,
	input wire logic i_evt_wakeup,
	input wire logic i_evt_orient,
	input wire logic i_smp_valid,
	input wire logic [`TSF_WORD_W-1:0] i_smp_word,
	input wire logic i_rd_req,
	input wire logic i_rd_restart,
	output logic o_rd_ready,
	output logic [`TSF_BYTE_W-1:0] o_rd_byte,
	output logic o_rd_valid,
	input wire logic i_rd_ack,
	output logic o_buffer_full_flag,
	output logic [`TSF_LEVEL_LO_W-1:0] o_buffer_stat_a_level,
	output logic [`TSF_LEVEL_W-`TSF_LEVEL_LO_W-1:0] o_buffer_stat_b_level_hi,
	output logic o_trig_latched
);
	import tsf_pkg::*;

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	localparam int AW = $clog2(DEPTH);
	localparam logic [`TSF_LEVEL_W-1:0] DEPTH_C = `TSF_LEVEL_W'(DEPTH);

	if ((DEPTH & (DEPTH - 1)) != 0 || DEPTH < `TSF_DEPTH_MIN || DEPTH > `TSF_DEPTH_MAX) begin
		$error("DEPTH must be a power of two from 4 to 512");
	end

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic line2;
	logic line2_prev_r;
	logic line2_rise;
	logic trig_mode;
	logic trig_seen_r;
	tsf_beh_t beh;
	logic clr;
	logic halt_r;
	logic [`TSF_WORD_W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [`TSF_LEVEL_W-1:0] mem_cnt_r;
	logic [`TSF_LEVEL_W-1:0] total;
	logic [`TSF_LEVEL_W-1:0] cap;
	logic has_room;
	logic store;
	logic drop;
	logic mv;
	logic skid_in_ready;
	logic skid_out_valid;
	logic [`TSF_WORD_W-1:0] skid_data;
	logic [1:0] skid_cnt;
	logic [2:0] ptr_r;
	logic [2:0] ptr_cur;
	logic accept;
	logic ser_pop;
	logic [`TSF_BYTE_W-1:0] rd_byte_r;
	logic rd_valid_r;
	logic full_r;
	logic [`TSF_LEVEL_W-1:0] level_r;

	// ------------------------------------------------------------
	// Trigger on line 2
	// ------------------------------------------------------------
	assign line2 = (i_evt_single_tap && i_route_single_tap_l2) ||
		(i_evt_double_tap && i_route_double_tap_l2) ||
		(i_evt_freefall && i_route_freefall_l2) ||
		(i_evt_wakeup && i_route_wakeup_l2) ||
		(i_evt_orient && i_route_orient_l2); // RULE_03
	assign line2_rise = line2 && !line2_prev_r; // RULE_04
	assign trig_mode = (i_buffer_ctrl_d_mode == `TSF_MODE_CONT_STOP) ||
		(i_buffer_ctrl_d_mode == `TSF_MODE_IDLE_CONT) ||
		(i_buffer_ctrl_d_mode == `TSF_MODE_IDLE_STOP);

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			line2_prev_r <= 1'b0;
		end else begin
			line2_prev_r <= line2;
		end
	end

	// Latch cleared only by bypass or an undescribed code
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			trig_seen_r <= 1'b0;
		end else if (line2_rise && trig_mode) begin
			trig_seen_r <= 1'b1; // RULE_04
		end else if (!trig_mode && i_buffer_ctrl_d_mode != `TSF_MODE_FIFO &&
			i_buffer_ctrl_d_mode != `TSF_MODE_CONT) begin
			trig_seen_r <= 1'b0; // RULE_05
		end
	end

	// ------------------------------------------------------------
	// Behaviour decode
	// ------------------------------------------------------------
	always_comb begin
		case (i_buffer_ctrl_d_mode)
			`TSF_MODE_BYPASS: beh = tsf_beh_clear; // RULE_23
			`TSF_MODE_FIFO: beh = tsf_beh_stop; // RULE_24
			`TSF_MODE_CONT: beh = tsf_beh_ring; // RULE_25
			`TSF_MODE_CONT_STOP: beh = trig_seen_r ? tsf_beh_stop : tsf_beh_ring; // RULE_01
			`TSF_MODE_IDLE_CONT: beh = trig_seen_r ? tsf_beh_ring : tsf_beh_clear; // RULE_11
			`TSF_MODE_IDLE_STOP: beh = trig_seen_r ? tsf_beh_stop : tsf_beh_clear; // RULE_13
			default: beh = tsf_beh_clear; // RULE_26
		endcase
	end

	assign clr = (beh == tsf_beh_clear);

	// ------------------------------------------------------------
	// Capacity and store decision
	// ------------------------------------------------------------
	assign total = mem_cnt_r + {{(`TSF_LEVEL_W-2){1'b0}}, skid_cnt};
	// Threshold above the array size would let the write index pass unread words
	assign cap = (i_stop_at_threshold && ({1'b0, i_threshold_level} < DEPTH_C)) ?
		{1'b0, i_threshold_level} : DEPTH_C; // RULE_07
	assign has_room = (total < cap);

	// Oldest word leaves the head when a full ring takes a new one
	assign drop = (beh == tsf_beh_ring) && i_smp_valid && !has_room &&
		(cap != '0) && skid_out_valid && !ser_pop; // RULE_25

	always_comb begin
		unique case (beh)
			tsf_beh_clear: store = 1'b0; // RULE_23
			tsf_beh_stop: store = i_smp_valid && has_room && !halt_r; // RULE_10
			tsf_beh_ring: store = i_smp_valid && (cap != '0) && (has_room || ser_pop || drop);
		endcase
	end

	// Once full in stop behaviour, no word is taken until cleared
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			halt_r <= 1'b0;
		end else if (clr) begin
			halt_r <= 1'b0;
		end else if (beh == tsf_beh_stop && !has_room) begin
			halt_r <= 1'b1; // RULE_09
		end
	end

	// ------------------------------------------------------------
	// Sample store
	// ------------------------------------------------------------
	assign mv = (mem_cnt_r != '0) && skid_in_ready;

	always_ff @(posedge i_ref_clk) begin
		if (store) begin
			mem[wr_ptr_r] <= i_smp_word;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else if (clr) begin
			wr_ptr_r <= '0; // RULE_23
			rd_ptr_r <= '0;
		end else begin
			if (store) begin
				wr_ptr_r <= wr_ptr_r + AW'(1);
			end
			if (mv) begin
				rd_ptr_r <= rd_ptr_r + AW'(1);
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mem_cnt_r <= '0;
		end else if (clr) begin
			mem_cnt_r <= '0;
		end else if (store && !mv) begin
			mem_cnt_r <= mem_cnt_r + `TSF_LEVEL_W'(1);
		end else if (mv && !store) begin
			mem_cnt_r <= mem_cnt_r - `TSF_LEVEL_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Output word buffer
	// ------------------------------------------------------------
	tsf_skid #(
		.W(`TSF_WORD_W)
	) u_skid (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_flush(clr),
		.i_in_valid(mem_cnt_r != '0),
		.o_in_ready(skid_in_ready),
		.i_in_data(mem[rd_ptr_r]),
		.o_out_valid(skid_out_valid),
		.i_out_ready(ser_pop || drop),
		.o_out_data(skid_data),
		.o_count(skid_cnt)
	);

	// ------------------------------------------------------------
	// Byte readout
	// ------------------------------------------------------------
	assign o_rd_ready = !rd_valid_r || i_rd_ack;
	assign accept = i_rd_req && o_rd_ready;
	assign ptr_cur = i_rd_restart ? `TSF_BYTE_FIRST : ptr_r;
	assign ser_pop = accept && (ptr_cur == `TSF_BYTE_LAST) && skid_out_valid; // RULE_16

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ptr_r <= `TSF_BYTE_FIRST;
		end else if (clr) begin
			ptr_r <= `TSF_BYTE_FIRST;
		end else if (accept) begin
			ptr_r <= (ptr_cur == `TSF_BYTE_LAST) ? `TSF_BYTE_FIRST : ptr_cur + 3'h1; // RULE_22
		end else if (i_rd_restart) begin
			ptr_r <= `TSF_BYTE_FIRST;
		end
	end

	// Empty buffer answers with a zero byte
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rd_byte_r <= `TSF_EMPTY_BYTE;
		end else if (accept) begin
			rd_byte_r <= skid_out_valid ? skid_data[`TSF_BYTE_W*ptr_cur +: `TSF_BYTE_W] :
				`TSF_EMPTY_BYTE; // RULE_17
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rd_valid_r <= 1'b0;
		end else if (accept) begin
			rd_valid_r <= 1'b1; // RULE_17
		end else if (i_rd_ack) begin
			rd_valid_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Status
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			full_r <= 1'b0;
		end else begin
			full_r <= !clr && (total + `TSF_LEVEL_W'(1) >= cap); // RULE_06 RULE_08 RULE_14
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			level_r <= '0;
		end else begin
			level_r <= total; // RULE_18
		end
	end

	assign o_rd_byte = rd_byte_r;
	assign o_rd_valid = rd_valid_r;
	assign o_buffer_full_flag = full_r;
	assign o_buffer_stat_a_level = level_r[`TSF_LEVEL_LO_W-1:0];
	assign o_buffer_stat_b_level_hi = level_r[`TSF_LEVEL_W-1:`TSF_LEVEL_LO_W];
	assign o_trig_latched = trig_seen_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	bypass_clears_a: // RULE_23
	assert property (clr ##1 clr |=> level_r == '0)
		else $error("buffer not empty after clear");

	trig_latch_a: // RULE_04
	assert property (line2_rise && trig_mode |=> trig_seen_r)
		else $error("first trigger edge not latched");

	trig_hold_a: // RULE_05
	assert property (trig_seen_r && trig_mode |=> trig_seen_r)
		else $error("trigger latch lost before bypass");

	idle_empty_a: // RULE_11
	assert property ((i_buffer_ctrl_d_mode == `TSF_MODE_IDLE_CONT ||
		i_buffer_ctrl_d_mode == `TSF_MODE_IDLE_STOP) && !trig_seen_r
		|=> mem_cnt_r == '0 && skid_cnt == 2'h0)
		else $error("idle mode stored a word");

	stop_hold_a: // RULE_09
	assert property (halt_r && beh == tsf_beh_stop |=> total <= $past(total))
		else $error("halted buffer grew");

	full_flag_a: // RULE_06
	assert property (!clr && !has_room |=> full_r)
		else $error("full flag missing at capacity");

	thr_cap_a: // RULE_08
	assert property (i_stop_at_threshold && !clr &&
		(total + `TSF_LEVEL_W'(1) >= {1'b0, i_threshold_level}) |=> o_buffer_full_flag)
		else $error("threshold full flag missing");

	ring_keep_a: // RULE_25
	assert property (drop && store |=> total == $past(total))
		else $error("ring overwrite changed level");

	byte_wrap_a: // RULE_22
	assert property (accept && ptr_cur == `TSF_BYTE_LAST && !clr |=> ptr_r == `TSF_BYTE_FIRST)
		else $error("byte pointer did not wrap to tag");

	read_load_a: // RULE_17
	assert property (accept |=> o_rd_valid)
		else $error("read did not load output byte");
endmodule

// ### hw/tsf_skid.sv
// Purpose: Two-entry buffer between sample store and byte readout
// Assumes: Single clock, asynchronous active-low reset
// Notes: Head word always sits in entry zero
`timescale 1ns/1ps
module tsf_skid #(
	parameter int W = 56
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data,
	output logic [1:0] o_count
);
	logic [W-1:0] d0_r;
	logic [W-1:0] d1_r;
	logic [1:0] cnt_r;
	logic push;
	logic pop;

	assign o_in_ready = (cnt_r != 2'h2);
	assign o_out_valid = (cnt_r != 2'h0);
	assign o_out_data = d0_r;
	assign o_count = cnt_r;
	assign push = i_in_valid && o_in_ready;
	assign pop = i_out_ready && o_out_valid;

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_r <= 2'h0;
		end else if (i_flush) begin
			cnt_r <= 2'h0;
		end else if (push && !pop) begin
			cnt_r <= cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_r <= cnt_r - 2'h1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			d0_r <= '0;
			d1_r <= '0;
		end else if (!i_flush) begin
			if (pop) begin
				d0_r <= (cnt_r == 2'h1) ? i_in_data : d1_r;
				if (push) begin
					d1_r <= i_in_data;
				end
			end else if (push) begin
				if (cnt_r == 2'h0) begin
					d0_r <= i_in_data;
				end else begin
					d1_r <= i_in_data;
				end
			end
		end
	end
endmodule

// ### shared/tsf_map.svh
// Purpose: Constants for the triggered sample buffer control
// Assumes: Included by its bare name
// Notes: Mode codes are the three-bit mode field of buffer_ctrl_d
`ifndef TSF_MAP_SVH
`define TSF_MAP_SVH

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define TSF_MODE_BYPASS 3'h0
`define TSF_MODE_FIFO 3'h1
`define TSF_MODE_CONT_STOP 3'h3
`define TSF_MODE_IDLE_CONT 3'h4
`define TSF_MODE_CONT 3'h6
`define TSF_MODE_IDLE_STOP 3'h7

// ----------------------------------------------------------------
// Word and level layout
// ----------------------------------------------------------------
`define TSF_WORD_W 56
`define TSF_BYTE_W 8
`define TSF_BYTE_FIRST 3'h0
`define TSF_BYTE_LAST 3'h6
`define TSF_LEVEL_W 10
`define TSF_LEVEL_LO_W 8
`define TSF_THR_W 9
`define TSF_DEPTH_DEF 512
`define TSF_DEPTH_MIN 4
`define TSF_DEPTH_MAX 512
`define TSF_EMPTY_BYTE 8'h00

`endif

// ### shared/tsf_pkg.sv
// Purpose: Types for the triggered sample buffer control
// Assumes: Nothing beyond the map header
// Notes: Behaviour codes are internal only
package tsf_pkg;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef logic [2:0] tsf_mode_t;

	typedef enum logic [1:0] {
		tsf_beh_clear = 2'b00,
		tsf_beh_stop = 2'b01,
		tsf_beh_ring = 2'b10
	} tsf_beh_t;

endpackage
